// [core/lsirc_pkg.sv]
// Shared constants and types for the light sensor register controller.
// Assumes a single 50 MHz system clock and a synchronous reset.
package lsirc_pkg;
  // Upper six bits of the bus address of the device
  localparam logic [5:0] ADDR_PREFIX = 6'b100010;
  // Register offsets
  localparam logic [7:0] REG_CMD_OFF = 8'h00;
  localparam logic [7:0] REG_CTRL_OFF = 8'h01;
  localparam logic [7:0] REG_THR_HI_OFF = 8'h02;
  localparam logic [7:0] REG_THR_LO_OFF = 8'h03;
  localparam logic [7:0] REG_LIGHT_LO_OFF = 8'h04;
  localparam logic [7:0] REG_LIGHT_HI_OFF = 8'h05;
  localparam logic [7:0] REG_TIMER_LO_OFF = 8'h06;
  localparam logic [7:0] REG_TIMER_HI_OFF = 8'h07;
  // Reset value and write masks
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] CMD_WRITE_MASK = 8'hef;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h0c;
  // Field positions
  localparam int CMD_ENABLE_BIT = 7;
  localparam int CMD_PDOWN_BIT = 6;
  localparam int CMD_TIMING_BIT = 5;
  localparam int PTR_SYNC_BIT = 7;
  localparam int PTR_CLEAR_BIT = 6;
  // Conversion modes
  localparam logic [1:0] MODE_LIGHT = 2'b10;
  localparam logic [1:0] MODE_NOP = 2'b11;
  // Oscillator cycles per conversion and counter full-scale values
  localparam int unsigned CYCLES_N16 = 65536;
  localparam logic [16:0] CYCLES_N12 = 17'h01000;
  localparam logic [16:0] CYCLES_N8 = 17'h00100;
  localparam logic [16:0] CYCLES_N4 = 17'h00010;
  localparam logic [14:0] LIGHT_MAX = 15'h7fff;
  localparam logic [15:0] TIMER_MAX = 16'hffff;

  typedef enum logic [2:0] {
    LSIRC_IDLE = 3'b000,
    LSIRC_ADDR = 3'b001,
    LSIRC_ACK_ADDR = 3'b010,
    LSIRC_WRITE = 3'b011,
    LSIRC_ACK_WRITE = 3'b100,
    LSIRC_READ = 3'b101,
    LSIRC_ACK_READ = 3'b110
  } lsirc_state_t;
endpackage : lsirc_pkg

// [core/lsirc_integrator.sv]
// Integration timing and count capture for the light converter.
// Assumes osc_tick and charge_pulse are one-cycle pulses on clk.
`timescale 1ns/10ps
module lsirc_integrator import lsirc_pkg::*; #(
  parameter int unsigned FULL_CYCLES = CYCLES_N16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Mode
  input wire logic run,
  input wire logic hold,
  input wire logic ext_timing,
  input wire logic [1:0] cycle_sel,
  input wire logic sync_cmd,
  // Converter front end
  input wire logic osc_tick,
  input wire logic charge_pulse,
  // Results
  output logic done,
  output logic [14:0] result,
  output logic [15:0] timer_out
);
  logic [16:0] limit;
  logic [15:0] timer_cnt_reg;
  logic [14:0] light_cnt_reg;
  logic [16:0] tick_next;
  logic end_now;

  always_comb begin
    case (cycle_sel) // [R22]
      2'b00: limit = 17'(FULL_CYCLES);
      2'b01: limit = CYCLES_N12;
      2'b10: limit = CYCLES_N8;
      default: limit = CYCLES_N4;
    endcase
  end

  assign tick_next = {1'b0, timer_cnt_reg} + 17'h00001;
  // Internal mode ends on the n-th tick, external on the sync command
  assign end_now = run && (ext_timing ? sync_cmd : // [R14] [R15]
                   (osc_tick && tick_next == limit)); // [R13]

  always_ff @(posedge clk) begin
    if (reset || (!run && !hold)) begin // [R19] [R21]
      timer_cnt_reg <= 16'h0000;
      light_cnt_reg <= 15'h0000;
    end else if (end_now) begin
      timer_cnt_reg <= 16'h0000;
      light_cnt_reg <= 15'h0000;
    end else if (run) begin
      if (osc_tick && timer_cnt_reg != TIMER_MAX)
        timer_cnt_reg <= tick_next[15:0];
      // Saturate rather than wrap so a bright scene reads full scale
      if (charge_pulse && light_cnt_reg != LIGHT_MAX) // [R12]
        light_cnt_reg <= light_cnt_reg + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      result <= 15'h0000;
      timer_out <= 16'h0000;
    end else begin
      done <= end_now;
      if (end_now) begin // [R11]
        result <= light_cnt_reg;
        timer_out <= ext_timing ? timer_cnt_reg : tick_next[15:0];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_no_done_idle;
    done |-> $past(run);
  endproperty
  a_no_done_idle: assert property (p_no_done_idle) // [R19]
    else $error("integration ended while converter disabled");

  property p_short_cycle;
    end_now && !ext_timing && cycle_sel == 2'b11 |=> timer_out == 16'h0010;
  endproperty
  a_short_cycle: assert property (p_short_cycle) // [R22]
    else $error("sixteen cycle conversion gave wrong timer");

  property p_sync_ends;
    run && ext_timing && sync_cmd |=> done ##1 !done;
  endproperty
  a_sync_ends: assert property (p_sync_ends) // [R15]
    else $error("sync command did not end integration");

  property p_internal_no_sync;
    run && !ext_timing && sync_cmd && !osc_tick |=> !done;
  endproperty
  a_internal_no_sync: assert property (p_internal_no_sync) // [R20]
    else $error("sync command acted in internal timing");

  c_done: cover property (done && ext_timing);
endmodule : lsirc_integrator

// [core/lsirc_i2c_slave.sv]
// Byte-level serial bus slave: address match, acknowledge, byte shift.
// Assumes scl_s and sda_s are already synchronised to clk.
`timescale 1ns/10ps
module lsirc_i2c_slave import lsirc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Synchronised bus lines
  input wire logic scl_s,
  input wire logic sda_s,
  // Drive of the data line, low only
  output logic sda_drive,
  // Identity and register side
  input wire logic [6:0] own_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  output logic wr_first,
  output logic [7:0] wr_byte
);
  lsirc_state_t state_reg;
  logic scl_d, sda_d, rw_reg, nack_reg, first_reg, have_bits_reg;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg, tx_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_cond = scl_s && scl_d && sda_d && !sda_s; // [R4]
  assign stop_cond = scl_s && scl_d && !sda_d && sda_s; // [R6]

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= LSIRC_IDLE;
      sda_drive <= 1'b0;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      first_reg <= 1'b0;
      have_bits_reg <= 1'b0;
      wr_valid <= 1'b0;
      wr_first <= 1'b0;
      wr_byte <= 8'h00;
    end else begin
      wr_valid <= 1'b0;
      if (start_cond) begin
        state_reg <= LSIRC_ADDR;
        bit_reg <= 3'h0;
        have_bits_reg <= 1'b0;
        sda_drive <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= LSIRC_IDLE;
        sda_drive <= 1'b0;
      end else begin
        case (state_reg)
          LSIRC_ADDR, LSIRC_WRITE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_reg <= bit_reg + 3'h1;
              have_bits_reg <= 1'b1;
            // The fall that ends the start condition carries no byte
            end else if (scl_fall && bit_reg == 3'h0 && have_bits_reg) begin
              have_bits_reg <= 1'b0;
              if (state_reg == LSIRC_ADDR) begin
                if (shift_reg[7:1] == own_addr) begin // [R2]
                  sda_drive <= 1'b1; // [R5]
                  rw_reg <= shift_reg[0];
                  first_reg <= 1'b1;
                  state_reg <= LSIRC_ACK_ADDR;
                end else begin
                  state_reg <= LSIRC_IDLE;
                end
              end else begin
                sda_drive <= 1'b1; // [R5]
                wr_valid <= 1'b1; // [R23]
                wr_first <= first_reg;
                wr_byte <= shift_reg;
                first_reg <= 1'b0;
                state_reg <= LSIRC_ACK_WRITE;
              end
            end
          end
          LSIRC_ACK_ADDR, LSIRC_ACK_WRITE: begin
            if (scl_fall) begin
              bit_reg <= 3'h0;
              if (state_reg == LSIRC_ACK_ADDR && rw_reg) begin
                tx_reg <= rd_data; // [R23]
                sda_drive <= !rd_data[7];
                state_reg <= LSIRC_READ;
              end else begin
                sda_drive <= 1'b0;
                state_reg <= LSIRC_WRITE;
              end
            end
          end
          LSIRC_READ: begin
            if (scl_fall) begin
              bit_reg <= bit_reg + 3'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              if (bit_reg == 3'h7) begin
                sda_drive <= 1'b0; // [R3]
                state_reg <= LSIRC_ACK_READ;
              end else begin
                sda_drive <= !tx_reg[6];
              end
            end
          end
          LSIRC_ACK_READ: begin
            if (scl_rise) begin
              nack_reg <= sda_s; // [R5]
            end else if (scl_fall) begin
              bit_reg <= 3'h0;
              if (nack_reg) begin
                state_reg <= LSIRC_IDLE;
              end else begin
                tx_reg <= rd_data;
                sda_drive <= !rd_data[7];
                state_reg <= LSIRC_READ;
              end
            end
          end
          default: state_reg <= LSIRC_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_ack_match;
    state_reg == LSIRC_ADDR ##1 state_reg == LSIRC_ACK_ADDR |->
      $past(shift_reg[7:1]) == own_addr;
  endproperty
  a_ack_match: assert property (p_ack_match) // [R2]
    else $error("acknowledged a foreign address");

  property p_ack_write_drive;
    state_reg == LSIRC_ACK_WRITE |-> sda_drive;
  endproperty
  a_ack_write_drive: assert property (p_ack_write_drive) // [R5]
    else $error("data byte not acknowledged");

  c_read: cover property (state_reg == LSIRC_ACK_READ);
endmodule : lsirc_i2c_slave

// [core/lsirc_top.sv]
// Register interface and conversion control of the light sensor.
// Assumes scl, sda and the address strap arrive asynchronously to clk;
// osc_tick and charge_pulse come from logic on clk.
// What this block does
// R1: Address is fixed prefix plus strap bit
// R2: Answer only to a matching address byte
// R3: Master drives clock; data shared by phase
// R4: Master opens with start then address byte
// R5: Receiver pulls data low in acknowledge
// R6: Master closes with a stop condition
// R7: Decode registers 00h-07h, reset zero
// R8: Command and control change only when written
// R9: Command and control field layout, zero bits
// R10: Four read-only bytes: light and timer
// R11: Data registers refresh at integration end
// R12: Light count is a saturating 15-bit value
// R13: Internal timing ends after n-bit count
// R14: External period spans two sync commands
// R15: Pointer bit 7 restarts integration externally
// R16: Pointer bit 6 clears pending interrupt
// R17: Four gain ranges selected over the bus
// R18: Two threshold registers, high and low
// R19: Enable bit low holds converter in reset
// R20: Timing select chooses internal or external
// R21: Only mode 10 converts; 11 holds
// R22: Cycle field picks 65536, 4096, 256, 16
// R23: First byte points, next writes, read returns
`timescale 1ns/10ps
module lsirc_top import lsirc_pkg::*; #(
  parameter int unsigned FULL_CYCLES = CYCLES_N16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strap
  input wire logic address_strap,
  // Converter front end
  input wire logic osc_tick,
  input wire logic charge_pulse,
  // Status to the analog side
  output logic converter_run_enable,
  output logic power_down_request,
  output logic [1:0] range_select,
  output logic interrupt_pending
);
  logic scl_m, scl_s, sda_m, sda_s, strap_m, strap_s;
  logic strap_taken_reg, strap_reg;
  logic [6:0] own_addr;
  logic wr_valid, wr_first, sda_drive;
  logic [7:0] wr_byte, rd_data;
  logic [7:0] pointer_reg, cmd_reg, ctrl_reg, thr_hi_reg, thr_lo_reg;
  logic [7:0] light_lo_reg, light_hi_reg, timer_lo_reg, timer_hi_reg;
  logic sync_cmd, clear_cmd, conv_done, conv_run, conv_hold;
  logic [14:0] conv_result;
  logic [15:0] conv_timer;
  logic int_set;

  // Two-stage synchronisers for the pins
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  // Strap keeps syncing through reset so its capture sees the real pin
  always_ff @(posedge clk) begin
    strap_m <= address_strap;
    strap_s <= strap_m;
  end

  // Strap is caught once after reset so the address cannot shift mid-frame
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_taken_reg <= 1'b0;
      strap_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_reg <= strap_s;
    end
  end

  assign own_addr = {ADDR_PREFIX, strap_reg}; // [R1]

  lsirc_i2c_slave u_slave (
    .clk(clk),
    .reset(reset),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .sda_drive(sda_drive),
    .own_addr(own_addr),
    .rd_data(rd_data),
    .wr_valid(wr_valid),
    .wr_first(wr_first),
    .wr_byte(wr_byte)
  );

  // Open drain: the line is only ever pulled low
  always_ff @(posedge clk) begin
    if (reset) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= sda_drive; // [R3]
    end
  end

  // Command bits in the pointer byte are not stored as a pointer
  assign sync_cmd = wr_valid && wr_first && wr_byte[PTR_SYNC_BIT]; // [R15]
  assign clear_cmd = wr_valid && wr_first && wr_byte[PTR_CLEAR_BIT]; // [R16]

  always_ff @(posedge clk) begin
    if (reset) begin
      pointer_reg <= REG_CMD_OFF;
    end else if (wr_valid && wr_first && !wr_byte[PTR_SYNC_BIT] &&
                 !wr_byte[PTR_CLEAR_BIT]) begin
      pointer_reg <= wr_byte; // [R23]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin // [R7]
      cmd_reg <= REG_RESET_VAL;
      ctrl_reg <= REG_RESET_VAL;
      thr_hi_reg <= REG_RESET_VAL;
      thr_lo_reg <= REG_RESET_VAL;
    end else if (wr_valid && !wr_first) begin // [R8]
      case (pointer_reg)
        REG_CMD_OFF: cmd_reg <= wr_byte & CMD_WRITE_MASK; // [R9]
        REG_CTRL_OFF: ctrl_reg <= wr_byte & CTRL_WRITE_MASK; // [R9] [R17]
        REG_THR_HI_OFF: thr_hi_reg <= wr_byte; // [R18]
        REG_THR_LO_OFF: thr_lo_reg <= wr_byte; // [R18]
        default: ;
      endcase
    end
  end

  always_comb begin
    case (pointer_reg) // [R10]
      REG_CMD_OFF: rd_data = cmd_reg;
      REG_CTRL_OFF: rd_data = ctrl_reg;
      REG_THR_HI_OFF: rd_data = thr_hi_reg;
      REG_THR_LO_OFF: rd_data = thr_lo_reg;
      REG_LIGHT_LO_OFF: rd_data = light_lo_reg;
      REG_LIGHT_HI_OFF: rd_data = light_hi_reg;
      REG_TIMER_LO_OFF: rd_data = timer_lo_reg;
      REG_TIMER_HI_OFF: rd_data = timer_hi_reg;
      default: rd_data = 8'h00;
    endcase
  end

  // Power-down stops conversion as well as the enable bit does
  assign conv_run = cmd_reg[CMD_ENABLE_BIT] && !cmd_reg[CMD_PDOWN_BIT] &&
                    cmd_reg[3:2] == MODE_LIGHT; // [R19] [R21]
  assign conv_hold = cmd_reg[CMD_ENABLE_BIT] && !cmd_reg[CMD_PDOWN_BIT] &&
                     cmd_reg[3:2] == MODE_NOP; // [R21]

  lsirc_integrator #(
    .FULL_CYCLES(FULL_CYCLES)
  ) u_integrator (
    .clk(clk),
    .reset(reset),
    .run(conv_run),
    .hold(conv_hold),
    .ext_timing(cmd_reg[CMD_TIMING_BIT]), // [R20]
    .cycle_sel(cmd_reg[1:0]), // [R22]
    .sync_cmd(sync_cmd),
    .osc_tick(osc_tick),
    .charge_pulse(charge_pulse),
    .done(conv_done),
    .result(conv_result),
    .timer_out(conv_timer)
  );

  always_ff @(posedge clk) begin
    if (reset) begin // [R7]
      light_lo_reg <= REG_RESET_VAL;
      light_hi_reg <= REG_RESET_VAL;
      timer_lo_reg <= REG_RESET_VAL;
      timer_hi_reg <= REG_RESET_VAL;
    end else if (conv_done) begin // [R11]
      light_lo_reg <= conv_result[7:0]; // [R12]
      light_hi_reg <= {1'b0, conv_result[14:8]};
      timer_lo_reg <= conv_timer[7:0];
      timer_hi_reg <= conv_timer[15:8];
    end
  end

  // High byte of the result is compared against the thresholds
  assign int_set = conv_done && (thr_hi_reg != 8'h00 || thr_lo_reg != 8'h00)
                   && ({1'b0, conv_result[14:8]} > thr_hi_reg ||
                       {1'b0, conv_result[14:8]} < thr_lo_reg);

  always_ff @(posedge clk) begin
    if (reset) begin
      interrupt_pending <= 1'b0;
    end else if (int_set) begin
      interrupt_pending <= 1'b1;
    end else if (clear_cmd) begin
      interrupt_pending <= 1'b0; // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      converter_run_enable <= 1'b0;
      power_down_request <= 1'b0;
      range_select <= 2'b00;
    end else begin
      converter_run_enable <= conv_run;
      power_down_request <= cmd_reg[CMD_PDOWN_BIT];
      range_select <= ctrl_reg[3:2]; // [R17]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_addr_prefix;
    strap_taken_reg |-> own_addr == {6'b100010, strap_reg};
  endproperty
  a_addr_prefix: assert property (p_addr_prefix) // [R1]
    else $error("slave address prefix wrong");

  property p_cmd_stable;
    $changed(cmd_reg) |-> $past(wr_valid && !wr_first &&
                                pointer_reg == REG_CMD_OFF);
  endproperty
  a_cmd_stable: assert property (p_cmd_stable) // [R8]
    else $error("command register changed without a write");

  property p_zero_bits;
    cmd_reg[4] == 1'b0 && ctrl_reg[7:4] == 4'h0 && ctrl_reg[1:0] == 2'b00;
  endproperty
  a_zero_bits: assert property (p_zero_bits) // [R9]
    else $error("reserved bits not zero");

  property p_data_refresh;
    conv_done |=> light_lo_reg == $past(conv_result[7:0]) &&
                  timer_hi_reg == $past(conv_timer[15:8]);
  endproperty
  a_data_refresh: assert property (p_data_refresh) // [R11]
    else $error("data registers not refreshed at integration end");

  property p_clear_int;
    clear_cmd && !int_set |=> !interrupt_pending;
  endproperty
  a_clear_int: assert property (p_clear_int) // [R16]
    else $error("interrupt not cleared");

  property p_set_wins;
    int_set |=> interrupt_pending;
  endproperty
  a_set_wins: assert property (p_set_wins) // [R16]
    else $error("interrupt event lost");

  property p_disabled_hold;
    !cmd_reg[CMD_ENABLE_BIT] |=> !converter_run_enable;
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) // [R19]
    else $error("converter ran while disabled");

  c_cmd_write: cover property (wr_valid && !wr_first &&
                               pointer_reg == REG_CMD_OFF);
  c_sync: cover property (sync_cmd);
  c_int: cover property (int_set);
endmodule : lsirc_top

// [tb/lsirc_master_model.sv]
// Bus master model that talks to the light sensor register controller.
// Assumes the bench makes the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module lsirc_master_model (
  // Pacing clock
  input wire logic clk,
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Clock low 5 clk, high 4 clk: the low phase is stretched by one clk
  // so the device's late acknowledge release lands before the rise
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task automatic bit_xfer(input logic d, output logic q);
    wait_clk(2);
    sda_pull = ~d;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(3);
    q = sda;
    wait_clk(1);
    scl = 1'b0;
  endtask : bit_xfer

  task automatic start_cond();
    sda_pull = 1'b0;
    scl = 1'b1;
    wait_clk(4);
    sda_pull = 1'b1;
    wait_clk(4);
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wait_clk(2);
    sda_pull = 1'b1;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    sda_pull = 1'b0;
    wait_clk(4);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack_n);
    logic q;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], q);
    bit_xfer(1'b1, ack_n);
  endtask : send_byte

  // Low on the ninth bit keeps the read going; high ends it
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
    bit_xfer(last, q);
  endtask : recv_byte
endmodule : lsirc_master_model

// [tb/lsirc_top_tb.sv]
// Self-checking bench for the light sensor register controller.
// Assumes the master model paces the bus; ticks come from this bench.
`timescale 1ns/10ps
module lsirc_top_tb;
  import lsirc_pkg::*;
  localparam int unsigned FULL = 64;
  logic clk, reset, scl, sda_line, m_pull, sda_out, sda_oe, strap;
  logic osc_tick, charge_pulse, run_en, pd_req, irq, a;
  logic [1:0] range_sel;
  logic [7:0] v, w;
  logic [15:0] t, l;
  int errors, samples_checked;
  int unsigned lim[4] = '{FULL, 4096, 256, 16};

  assign sda_line = !(m_pull || sda_oe);
  always #10 clk = ~clk;
  // One-cycle tick every 2 clk; charge pulses in the same cycle so counts are exact
  always @(negedge clk) begin
    osc_tick <= ~osc_tick;
    charge_pulse <= ~osc_tick;
  end

  lsirc_master_model m (.clk(clk), .scl(scl), .sda_pull(m_pull),
    .sda(sda_line));
  lsirc_top #(.FULL_CYCLES(FULL)) i_dut (.clk(clk), .reset(reset),
    .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap(strap), .osc_tick(osc_tick),
    .charge_pulse(charge_pulse), .converter_run_enable(run_en),
    .power_down_request(pd_req), .range_select(range_sel),
    .interrupt_pending(irq));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic write_bus(input logic [7:0] ptr, input logic [7:0] d,
    input logic with_d);
    logic k;
    m.start_cond();
    m.send_byte({ADDR_PREFIX, strap, 1'b0}, k);
    check({15'h0, k}, 16'h0);
    m.send_byte(ptr, k);
    check({15'h0, k}, 16'h0);
    if (with_d) begin
      m.send_byte(d, k);
      check({15'h0, k}, 16'h0);
    end
    m.stop_cond();
  endtask : write_bus

  task automatic read_cur(output logic [7:0] r);
    logic k;
    m.start_cond();
    m.send_byte({ADDR_PREFIX, strap, 1'b1}, k);
    check({15'h0, k}, 16'h0);
    m.recv_byte(1'b1, r);
    m.stop_cond();
  endtask : read_cur

  task automatic expect_reg(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] r;
    write_bus(ptr, 8'h00, 1'b0);
    read_cur(r);
    check({8'h0, r}, {8'h0, exp});
  endtask : expect_reg

  task automatic wrong_addr();
    m.start_cond();
    m.send_byte({ADDR_PREFIX, ~strap, 1'b0}, a);
    check({15'h0, a}, 16'h1);
    m.stop_cond();
  endtask : wrong_addr

  task automatic read16(input logic [7:0] lo, output logic [15:0] r);
    logic [7:0] r0, r1;
    write_bus(lo, 8'h00, 1'b0);
    read_cur(r0);
    write_bus(lo + 8'h01, 8'h00, 1'b0);
    read_cur(r1);
    r = {r1, r0};
  endtask : read16

  initial begin
    clk = 0; reset = 1; strap = 0; osc_tick = 0; charge_pulse = 0;
    errors = 0; samples_checked = 0;
    m.wait_clk(12);
    reset = 0;
    m.wait_clk(8);
    for (int i = 0; i < 8; i++) expect_reg(i[7:0], 8'h00);
    expect_reg(8'h09, 8'h00);
    wrong_addr();
    $display("test done: reset values and address");
    write_bus(REG_CMD_OFF, 8'hff, 1'b1);
    expect_reg(REG_CMD_OFF, 8'hef);
    write_bus(REG_CTRL_OFF, 8'hff, 1'b1);
    expect_reg(REG_CTRL_OFF, 8'h0c);
    check({14'h0, range_sel}, 16'h3);
    check({15'h0, pd_req}, 16'h1);
    write_bus(REG_LIGHT_LO_OFF, 8'haa, 1'b1);
    expect_reg(REG_LIGHT_LO_OFF, 8'h00);
    $display("test done: field layout");
    for (int i = 0; i < 4; i++) begin
      write_bus(REG_CMD_OFF, {6'b100000 | 6'(i), 2'b11}, 1'b1);
      m.wait_clk(4);
      check({15'h0, run_en}, {15'h0, i == 2});
    end
    write_bus(REG_CMD_OFF, 8'h0b, 1'b1);
    m.wait_clk(4);
    check({15'h0, run_en}, 16'h0);
    write_bus(REG_CMD_OFF, 8'hcb, 1'b1);
    m.wait_clk(4);
    check({14'h0, run_en, pd_req}, 16'h1);
    $display("test done: modes");
    for (int f = 0; f < 4; f++) begin
      // Disable first so a longer count left over cannot skip the limit
      write_bus(REG_CMD_OFF, 8'h00, 1'b1);
      write_bus(REG_CMD_OFF, {4'b1000, MODE_LIGHT, f[1:0]}, 1'b1);
      m.wait_clk(lim[f] * 4 + 200);
      read16(REG_TIMER_LO_OFF, t);
      check(t, lim[f][15:0]);
      read16(REG_LIGHT_LO_OFF, l);
      check(l, lim[f][15:0] - 16'h0001);
      expect_reg(REG_CMD_OFF, {4'b1000, MODE_LIGHT, f[1:0]});
    end
    $display("test done: internal timing");
    write_bus(REG_THR_HI_OFF, 8'hff, 1'b1);
    write_bus(REG_THR_LO_OFF, 8'h05, 1'b1);
    m.wait_clk(200);
    check({15'h0, irq}, 16'h1);
    // Stop conversions first: a new result would set the flag again
    write_bus(REG_CMD_OFF, 8'h00, 1'b1);
    write_bus(8'h40, 8'h00, 1'b0);
    m.wait_clk(8);
    check({15'h0, irq}, 16'h0);
    expect_reg(REG_THR_LO_OFF, 8'h05);
    $display("test done: interrupt");
    write_bus(REG_CMD_OFF, 8'ha8, 1'b1);
    write_bus(REG_CTRL_OFF, 8'h00, 1'b0);
    write_bus(8'h80, 8'h00, 1'b0);
    m.wait_clk(400);
    write_bus(8'h80, 8'h00, 1'b0);
    m.wait_clk(20);
    read_cur(v);
    check({8'h0, v}, 16'h000c);
    read16(REG_TIMER_LO_OFF, t);
    read16(REG_LIGHT_LO_OFF, l);
    check({15'h0, t >= 16'd260 && t <= 16'd320}, 16'h1);
    check(l, t);
    $display("test done: external timing");
    reset = 1;
    strap = 1;
    m.wait_clk(12);
    reset = 0;
    m.wait_clk(8);
    expect_reg(REG_CMD_OFF, 8'h00);
    wrong_addr();
    $display("test done: strap address");
    give_verdict();
  end

  initial begin
    m.wait_clk(60000);
    errors++;
    $display("[FAIL] %0t ns: run did not finish in time", $time);
    give_verdict();
  end
endmodule : lsirc_top_tb
